// file: hw/rarc_pkg.sv
// Purpose: Shared constants and types for the alarm repeat counter block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses

`default_nettype none

package rarc_pkg;

    localparam logic [11:0] ADDR_ALARM_CONTROL = 12'h0_000;
    localparam logic [11:0] ADDR_MODULE_CONTROL = 12'h0_004;
    localparam logic [11:0] ADDR_EVENT_STATUS = 12'h0_008;
    localparam logic [11:0] ADDR_EVENT_MASK = 12'h0_00C;

    // Alarm control field positions
    localparam int REPEAT_LSB = 0;
    localparam int REPEAT_MSB = 7;
    localparam int WRAP_BIT = 14;
    localparam int ENABLE_BIT = 15;
    localparam int SYNC_BIT = 12;

    // Module control
    localparam int MODULE_ON_BIT = 15;

    // Status and mask bit positions
    localparam int ST_ALARM_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_WRAP_BIT = 2;
    localparam int ST_WIDTH = 3;

    localparam logic [7:0] REPEAT_RESET = 8'h00;
    localparam logic [7:0] REPEAT_ZERO = 8'h00;
    localparam logic [7:0] REPEAT_ALL_ONES = 8'hFF;
    localparam logic [ST_WIDTH-1:0] ST_RESET = 3'h0;

    // Synchronisation window length in peripheral bus clocks
    localparam int SYNC_WINDOW_CLKS = 32;
    localparam logic [5:0] SYNC_WINDOW_COUNT = 6'(SYNC_WINDOW_CLKS);

    typedef struct packed {
        logic enable;
        logic wrap;
        logic [7:0] repeat_count;
    } rarc_alarm_t;

    localparam rarc_alarm_t ALARM_RESET = '{enable: 1'b0, wrap: 1'b0,
                                            repeat_count: REPEAT_RESET};

endpackage

`default_nettype wire

// file: hw/rarc_top.sv
// Purpose: Alarm repeat counter of a real-time clock, with APB register access
// Assumes: alarm_event is a one-cycle pulse from the same-clock match logic
// Notes: Alarm control resets only on por_n, other state on presetn
//
// Functional notes
// - With repeat-wrap clear, the alarm fires one more time than the repeat count: 0xFF gives 256 firings, zero gives one.
// - Every alarm event taken while enabled decrements a nonzero repeat count by one.
// - At count zero an event wraps the count to 0xFF only in repeat-wrap mode.
// - At count zero with repeat-wrap clear, an event clears the alarm enable bit.
// - The alarm control register is reset only by power-on reset.

`timescale 1ns/1ns
`default_nettype none

module rarc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic alarm_event,
    input wire logic sync_request,
    output logic alarm_fire,
    output logic alarm_enable_bit,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // State

    rarc_pkg::rarc_alarm_t alarm_reg;
    rarc_pkg::rarc_alarm_t alarm_next;
    logic module_on_reg;
    logic module_on_next;
    logic [rarc_pkg::ST_WIDTH-1:0] status_reg;
    logic [rarc_pkg::ST_WIDTH-1:0] status_next;
    logic [rarc_pkg::ST_WIDTH-1:0] mask_reg;
    logic [rarc_pkg::ST_WIDTH-1:0] mask_next;
    logic [5:0] sync_cnt_reg;
    logic [5:0] sync_cnt_next;
    logic sync_open_next;
    logic [31:0] prdata_next;
    logic pready_next;
    logic pslverr_next;
    logic fire_reg;
    logic fire_next;
    logic irq_next;

    logic setup_phase;
    logic access_phase;
    logic wr_en;
    logic rd_en;
    logic wr_alarm;
    logic wr_module;
    logic wr_status;
    logic wr_mask;
    logic take_event;
    logic at_zero;
    logic [rarc_pkg::ST_WIDTH-1:0] ev_set;

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic addr_known(input logic [11:0] a);
        addr_known = (a == rarc_pkg::ADDR_ALARM_CONTROL) ||
                     (a == rarc_pkg::ADDR_MODULE_CONTROL) ||
                     (a == rarc_pkg::ADDR_EVENT_STATUS) ||
                     (a == rarc_pkg::ADDR_EVENT_MASK);
    endfunction

    // Read image of a flag register; unused upper bits read as zero
    function automatic logic [31:0] flag_word(input logic [rarc_pkg::ST_WIDTH-1:0] f);
        flag_word = 32'h0000_0000;
        flag_word[rarc_pkg::ST_WIDTH-1:0] = f;
    endfunction

    function automatic logic [31:0] alarm_word(input rarc_pkg::rarc_alarm_t al,
                                               input logic sync_open);
        alarm_word = 32'h0000_0000;
        alarm_word[rarc_pkg::REPEAT_MSB:rarc_pkg::REPEAT_LSB] = al.repeat_count;
        alarm_word[rarc_pkg::WRAP_BIT] = al.wrap;
        alarm_word[rarc_pkg::ENABLE_BIT] = al.enable;
        alarm_word[rarc_pkg::SYNC_BIT] = sync_open;
    endfunction

    // Count after one accepted event; zero holds unless repeat-wrap is set
    function automatic logic [7:0] count_after(input logic [7:0] count, input logic wrap);
        if (count != rarc_pkg::REPEAT_ZERO) begin
            count_after = count - 8'h01;
        end else if (wrap) begin
            count_after = rarc_pkg::REPEAT_ALL_ONES;
        end else begin
            count_after = rarc_pkg::REPEAT_ZERO;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus phases and write strobes

    // Zero wait states: the setup cycle decides the answer, the access edge commits
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign wr_en = access_phase && pwrite && addr_known(paddr);
    assign rd_en = setup_phase && !pwrite;
    assign wr_alarm = wr_en && (paddr == rarc_pkg::ADDR_ALARM_CONTROL);
    assign wr_module = wr_en && (paddr == rarc_pkg::ADDR_MODULE_CONTROL);
    assign wr_status = wr_en && (paddr == rarc_pkg::ADDR_EVENT_STATUS);
    assign wr_mask = wr_en && (paddr == rarc_pkg::ADDR_EVENT_MASK);

    // Events are dropped, not queued, while the enable is clear
    assign take_event = alarm_event && alarm_reg.enable;
    assign at_zero = (alarm_reg.repeat_count == rarc_pkg::REPEAT_ZERO);

    ////////////////////////////////////////////////////////////////////////
    // Alarm control, power-on domain

    always_comb begin
        alarm_next = alarm_reg;
        ev_set = '0;
        if (wr_alarm) begin
            alarm_next.repeat_count = pwdata[rarc_pkg::REPEAT_MSB:rarc_pkg::REPEAT_LSB];
            alarm_next.wrap = pwdata[rarc_pkg::WRAP_BIT];
            alarm_next.enable = pwdata[rarc_pkg::ENABLE_BIT];
        end
        // Event wins only the repeat count over a same-cycle write; written wrap and enable land unless the event clears enable
        if (take_event) begin
            ev_set[rarc_pkg::ST_ALARM_BIT] = 1'b1;
            alarm_next.repeat_count = count_after(alarm_reg.repeat_count, alarm_reg.wrap);
            if (at_zero && alarm_reg.wrap) begin
                ev_set[rarc_pkg::ST_WRAP_BIT] = 1'b1;
            end
            if (at_zero && !alarm_reg.wrap) begin
                alarm_next.enable = 1'b0;
                ev_set[rarc_pkg::ST_DONE_BIT] = 1'b1;
            end
        end
    end

    // The enable output mirrors the enable bit, so it shares its reset
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            alarm_reg <= rarc_pkg::ALARM_RESET;
            alarm_enable_bit <= rarc_pkg::ALARM_RESET.enable;
        end else begin
            alarm_reg <= alarm_next;
            alarm_enable_bit <= alarm_next.enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fire pulse: one cycle per accepted event

    always_comb begin
        fire_next = take_event;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fire_reg <= 1'b0;
        end else begin
            fire_reg <= fire_next;
        end
    end

    assign alarm_fire = fire_reg;

    ////////////////////////////////////////////////////////////////////////
    // Sync window: opens on request, closes after the window length

    // Software must finish its read inside the window; the block only reports it
    always_comb begin
        sync_cnt_next = sync_cnt_reg;
        if (sync_request && module_on_reg) begin
            sync_cnt_next = rarc_pkg::SYNC_WINDOW_COUNT;
        end else if (sync_cnt_reg != 6'h00) begin
            sync_cnt_next = sync_cnt_reg - 6'h01;
        end
        sync_open_next = (sync_cnt_next != 6'h00);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_cnt_reg <= 6'h00;
        end else begin
            sync_cnt_reg <= sync_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Module control

    always_comb begin
        module_on_next = module_on_reg;
        if (wr_module) begin
            module_on_next = pwdata[rarc_pkg::MODULE_ON_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            module_on_reg <= 1'b0;
        end else begin
            module_on_reg <= module_on_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event mask

    always_comb begin
        mask_next = mask_reg;
        if (wr_mask) begin
            mask_next = pwdata[rarc_pkg::ST_WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= rarc_pkg::ST_RESET;
        end else begin
            mask_reg <= mask_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event status, write one to clear

    always_comb begin
        status_next = status_reg;
        if (wr_status) begin
            status_next = status_reg & ~pwdata[rarc_pkg::ST_WIDTH-1:0];
        end
        // Set wins, so no event is lost to a racing clear
        status_next = status_next | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= rarc_pkg::ST_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt: level, high while an unmasked flag is set

    always_comb begin
        irq_next = |(status_next & mask_next);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus answer, registered at the setup edge

    // Read data is taken at the setup edge and stands through the access cycle
    always_comb begin
        pready_next = setup_phase;
        pslverr_next = setup_phase && !addr_known(paddr);
        prdata_next = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                rarc_pkg::ADDR_ALARM_CONTROL: begin
                    prdata_next = alarm_word(alarm_next, sync_open_next);
                end
                rarc_pkg::ADDR_MODULE_CONTROL: begin
                    prdata_next[rarc_pkg::MODULE_ON_BIT] = module_on_next;
                end
                rarc_pkg::ADDR_EVENT_STATUS: begin
                    prdata_next = flag_word(status_next);
                end
                rarc_pkg::ADDR_EVENT_MASK: begin
                    prdata_next = flag_word(mask_next);
                end
                default: begin
                    prdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
        end
    end

endmodule

`default_nettype wire

// file: tb/rarc_chk.sv
// Purpose: Port assertions for the alarm repeat counter
// Assumes: Zero-wait APB slave, one-cycle event pulses
// Notes: Bound to rarc_top
`timescale 1ns/1ns
`default_nettype none
module rarc_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic alarm_event,
    input wire logic alarm_fire,
    input wire logic alarm_enable_bit
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    fire_on_event_a: assert property (alarm_event && alarm_enable_bit |=> alarm_fire)
        else $error("missing fire");
    no_fire_off_a: assert property (!(alarm_event && alarm_enable_bit) |=> !alarm_fire)
        else $error("stray fire");
    fire_cause_a: assert property (alarm_fire |-> $past(alarm_event))
        else $error("fire without event");
    off_stays_a: assert property (!alarm_enable_bit && !psel |=> !alarm_enable_bit)
        else $error("enable set itself");
    on_stays_a: assert property (alarm_enable_bit && !alarm_event && !psel |=> alarm_enable_bit)
        else $error("enable lost");
    ready_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready");
    ready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
        else $error("ready misplaced");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule
bind rarc_top rarc_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .alarm_event(alarm_event),
    .alarm_fire(alarm_fire), .alarm_enable_bit(alarm_enable_bit));
`default_nettype wire

// file: tb/testbench.sv
// Purpose: Self-checking bench for the alarm repeat counter
// Assumes: Zero-wait APB, 25 MHz pclk
// Notes: Row table first, then reset, error and irq cases
`timescale 1ns/1ns
`default_nettype none
module testbench;
    typedef struct packed {
        logic [7:0] c;
        logic w;
        logic [8:0] n;
        logic [15:0] e;
        logic [8:0] f;
    } rarc_row_t;
    localparam logic [11:0] AC = rarc_pkg::ADDR_ALARM_CONTROL;
    logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, alarm_event = 0, sync_request = 0, alarm_fire, alarm_enable_bit;
    logic irq, err;
    int n_errors = 0, samples_checked = 0, fires = 0, cyc = 0;
    // Counts, wrap, events, expected word, expected firings
    rarc_row_t rows[6] = '{'{8'h00, 0, 1, 16'h0000, 1}, '{8'h00, 1, 1, 16'hC0FF, 1},
        '{8'h05, 0, 3, 16'h8002, 3}, '{8'h03, 0, 6, 16'h0000, 4},
        '{8'hFF, 0, 256, 16'h0000, 256}, '{8'h01, 1, 3, 16'hC0FE, 3}};
    always #20 pclk = ~pclk;
    rarc_top dut_u (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .alarm_event(alarm_event),
        .sync_request(sync_request), .alarm_fire(alarm_fire),
        .alarm_enable_bit(alarm_enable_bit),
        .irq(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("errors=%0d checks=%0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Extra edge at the end keeps back-to-back calls off one time step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++t < 40);
        if (t >= 40) n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic ev;
        alarm_event <= 1'b1;
        @(posedge pclk);
        alarm_event <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rst(input logic p);
        presetn <= 1'b0;
        por_n <= p;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge pclk);
        apb(1'b0, AC, '0);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (alarm_fire === 1'b1) fires++;
        if (cyc == 5000) begin
            n_errors++;
            wrap_up;
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge pclk);
        // Module stays off, so count writes never meet a sync window
        foreach (rows[i]) begin
            apb(1'b1, AC, {16'h0000, 1'b1, rows[i].w, 6'h00, rows[i].c});
            fires = 0;
            repeat (rows[i].n) ev;
            apb(1'b0, AC, '0);
            chk(rd & 32'h0000_C0FF, {16'h0000, rows[i].e});
            chk(32'(fires), 32'(rows[i].f));
        end
        apb(1'b0, rarc_pkg::ADDR_EVENT_STATUS, '0);
        chk(rd, 32'h0000_0007);
        apb(1'b1, AC, 32'h0000_8042);
        rst(1'b1);
        chk(rd & 32'h0000_C0FF, 32'h0000_8042);
        rst(1'b0);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 12'h010, '0);
        chk(32'(err), 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        apb(1'b1, AC, 32'h0000_8010);
        ev;
        chk(32'(irq), 32'h0000_0000);
        apb(1'b1, rarc_pkg::ADDR_EVENT_MASK, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0001);
        apb(1'b1, rarc_pkg::ADDR_EVENT_STATUS, 32'h0000_0007);
        @(posedge pclk);
        chk(32'(irq), 32'h0000_0000);
        // Sync window: open just after the request, shut one window length later
        apb(1'b1, rarc_pkg::ADDR_MODULE_CONTROL, 32'h0000_8000);
        apb(1'b0, rarc_pkg::ADDR_MODULE_CONTROL, '0);
        chk(rd, 32'h0000_8000);
        sync_request <= 1'b1;
        @(posedge pclk);
        sync_request <= 1'b0;
        apb(1'b0, AC, '0);
        chk(rd & 32'h0000_1000, 32'h0000_1000);
        repeat (rarc_pkg::SYNC_WINDOW_CLKS - 5) @(posedge pclk);
        apb(1'b0, AC, '0);
        chk(rd & 32'h0000_1000, 32'h0000_1000);
        apb(1'b0, AC, '0);
        chk(rd & 32'h0000_1000, 32'h0000_0000);
        wrap_up;
    end
endmodule
`default_nettype wire
